// file: rtl/dsc_regs.svh
// constants of the serial converter control link
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH
`define DSC_WORD_BITS 18
`define DSC_RESET_MID 18'h20000
`define DSC_RESET_ZERO 18'h00000
`define DSC_SIGN_BIT 17
`define DSC_CNT_BITS 5
`define DSC_CTRL_OFS 4'h0
`define DSC_TXDATA_OFS 4'h1
`define DSC_RXDATA_OFS 4'h2
`define DSC_STATUS_OFS 4'h3
`define DSC_DIVIDER_OFS 4'h4
`define DSC_CTRL_RESET 8'h00
`define DSC_DIV_RESET 8'h04
`define DSC_CS_HIGH_NS 60
`define DSC_LOAD_LOW_NS 20
`define DSC_CLK_NS 50
`define DSC_CS_HIGH_CYC ((`DSC_CS_HIGH_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_LOAD_LOW_CYC ((`DSC_LOAD_LOW_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`endif

// file: rtl/dsc_pkg.sv
// types shared by both ends of the converter link
package dsc_pkg;
    typedef logic [17:0] dsc_word_t;
    typedef enum logic [1:0] {DSC_GAIN_ONE, DSC_GAIN_TWO} dsc_gain_t;
endpackage : dsc_pkg

// file: rtl/dsc_link_if.sv
// serial link between host and converter control
`timescale 1ns/1ps
interface dsc_link_if;
    logic sclk;
    logic sdi;
    logic cs_n;
    logic load_latch_n;
    logic sdo_o;
    logic sdo_oe;
    logic sdo_i;
    modport dev (input sclk, input sdi, input cs_n, input load_latch_n,
        output sdo_o, output sdo_oe);
    modport host (output sclk, output sdi, output cs_n, output load_latch_n,
        input sdo_i);
endinterface : dsc_link_if

// file: rtl/dsc_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module dsc_buf2
    import dsc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input dsc_word_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output dsc_word_t out_data
);
    dsc_word_t mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;
    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            if (push && !pop) count <= count + 2'h1;
            else if (pop && !push) count <= count - 2'h1;
        end
    end
    always_ff @(posedge mclk) begin
        if (push) mem[wr_ptr] <= in_data;
    end
endmodule : dsc_buf2

// file: rtl/dsc_device.sv
// converter control end: serial input, readback, latch and straps
// Contract
// - reset loads mid or zero by select
// - gain strap picks buffer gain one or two
// - format select: straight binary or twos complement
// - low reset input reloads the reset value
// - power down grounds the output, no drive
// - shift bits only while chip select low
// - drive output in frame, release when high
// - stand-alone readback shifts out input register
// - daisy-chain readback shifts out shift register
// - output changes after falling clock edge
// - host samples output on rising edge
// - host starts frames with clock low
// - host raises select after last edge, gaps
// - host pulses load after select rises
// - host clocks whole chain in one frame
// - load low keeps latch transparent
`timescale 1ns/1ps
`include "dsc_regs.svh"
module dsc_device
    import dsc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    dsc_link_if.dev link,
    input wire logic reset_n,
    input wire logic reset_value_select,
    input wire logic gain_select,
    input wire logic number_format_select,
    input wire logic power_down_in,
    input wire logic readback_source_select,
    output dsc_word_t latch_code,
    output dsc_word_t dac_code,
    output dsc_gain_t buffer_gain,
    output logic output_driven,
    output logic output_grounded
);
    logic [1:0] sclk_s;
    logic [1:0] sdi_s;
    logic [1:0] cs_s;
    logic [1:0] ld_s;
    logic [1:0] rst_s;
    logic [1:0] rsel_s;
    logic [1:0] gain_s;
    logic [1:0] fmt_s;
    logic [1:0] pd_s;
    logic [1:0] sel_s;
    logic sclk_d;
    logic cs_d;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_fall;
    logic in_frame;
    logic soft_reset;
    logic [2:0] boot;
    dsc_word_t shift_reg;
    dsc_word_t input_reg;
    dsc_word_t out_shift;
    dsc_word_t reset_code;
    logic out_bit;
    logic buf_valid;
    logic buf_ready;
    dsc_word_t buf_data;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclk_s <= 2'h0;
            sdi_s <= 2'h0;
            cs_s <= 2'h3;
            ld_s <= 2'h3;
            rst_s <= 2'h3;
            rsel_s <= 2'h0;
            gain_s <= 2'h0;
            fmt_s <= 2'h0;
            pd_s <= 2'h0;
            sel_s <= 2'h0;
        end else begin
            sclk_s <= {sclk_s[0], link.sclk};
            sdi_s <= {sdi_s[0], link.sdi};
            cs_s <= {cs_s[0], link.cs_n};
            ld_s <= {ld_s[0], link.load_latch_n};
            rst_s <= {rst_s[0], reset_n};
            rsel_s <= {rsel_s[0], reset_value_select};
            gain_s <= {gain_s[0], gain_select};
            fmt_s <= {fmt_s[0], number_format_select};
            pd_s <= {pd_s[0], power_down_in};
            sel_s <= {sel_s[0], readback_source_select};
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s[1];
            cs_d <= cs_s[1];
        end
    end

    // power-on load waits for synced straps
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            boot <= 3'h0;
        end else begin
            boot <= {boot[1:0], 1'b1};
        end
    end

    assign sclk_rise = sclk_s[1] && !sclk_d;
    assign sclk_fall = !sclk_s[1] && sclk_d;
    assign cs_fall = !cs_s[1] && cs_d;
    assign cs_rise = cs_s[1] && !cs_d;
    assign in_frame = !cs_s[1];
    assign soft_reset = !rst_s[1] || !boot[2];

    assign reset_code = rsel_s[1] ? `DSC_RESET_MID : `DSC_RESET_ZERO;

    // sample on rising edge inside a frame only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shift_reg <= `DSC_RESET_ZERO;
        end else if (in_frame && sclk_rise) begin
            shift_reg <= {shift_reg[`DSC_WORD_BITS-2:0], sdi_s[1]};
        end
    end

    // committed word queued on select rise
    dsc_buf2 u_buf (
        .mclk(mclk),
        .rst(rst),
        .in_valid(cs_rise),
        .in_ready(),
        .in_data(shift_reg),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );
    assign buf_ready = !soft_reset;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            input_reg <= `DSC_RESET_ZERO;
        end else if (soft_reset) begin
            input_reg <= reset_code;
        end else if (buf_valid) begin
            // twos complement flips the sign bit
            input_reg <= buf_data ^ {!fmt_s[1], {(`DSC_WORD_BITS-1){1'b0}}};
        end
    end

    // latch follows input while load is low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            latch_code <= `DSC_RESET_ZERO;
        end else if (soft_reset) begin
            latch_code <= reset_code;
        end else if (!ld_s[1]) begin
            latch_code <= input_reg;
        end
    end

    // readback source chosen at frame start and again at each falling edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_shift <= `DSC_RESET_ZERO;
            out_bit <= 1'b0;
        end else if (cs_fall) begin
            out_shift <= {(sel_s[1] ? input_reg[`DSC_WORD_BITS-2:0]
                : shift_reg[`DSC_WORD_BITS-2:0]), 1'b0};
            out_bit <= sel_s[1] ? input_reg[`DSC_SIGN_BIT] : shift_reg[`DSC_SIGN_BIT];
        end else if (in_frame && sclk_fall) begin
            // new bit only after a falling edge
            out_bit <= sel_s[1] ? out_shift[`DSC_SIGN_BIT] : shift_reg[`DSC_SIGN_BIT];
            out_shift <= {out_shift[`DSC_WORD_BITS-2:0], 1'b0};
        end
    end

    assign link.sdo_o = out_bit;
    assign link.sdo_oe = in_frame;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            buffer_gain <= DSC_GAIN_ONE;
        end else begin
            buffer_gain <= gain_s[1] ? DSC_GAIN_TWO : DSC_GAIN_ONE;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            output_driven <= 1'b0;
            output_grounded <= 1'b1;
            dac_code <= `DSC_RESET_ZERO;
        end else begin
            output_driven <= !pd_s[1];
            output_grounded <= pd_s[1];
            dac_code <= pd_s[1] ? `DSC_RESET_ZERO : latch_code;
        end
    end
endmodule : dsc_device

// file: rtl/dsc_host.sv
// host end: frames words out, reads back, pulses load
`timescale 1ns/1ps
`include "dsc_regs.svh"
module dsc_host
    import dsc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    dsc_link_if.host link,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_END, H_GAP, H_LOAD} dsc_hstate_t;
    dsc_hstate_t state;
    logic [1:0] sdo_s;
    logic [7:0] ctrl;
    logic [7:0] divider;
    logic [7:0] div_cnt;
    logic [`DSC_CNT_BITS+1:0] bit_cnt;
    logic [7:0] gap_cnt;
    logic [53:0] tx_shift;
    dsc_word_t rx_shift;
    dsc_word_t rx_word;
    logic busy;
    logic done;
    logic start;
    logic [`DSC_CNT_BITS+1:0] total_bits;
    assign start = wr && addr == `DSC_CTRL_OFS && wdata[0];
    // ctrl[2:1] chained devices count minus one, ctrl[3] pulse load
    assign total_bits = (`DSC_CNT_BITS+2)'(`DSC_WORD_BITS * (ctrl[2:1] + 2'h1));
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sdo_s <= 2'h0;
        end else begin
            sdo_s <= {sdo_s[0], link.sdo_i};
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl <= `DSC_CTRL_RESET;
            divider <= `DSC_DIV_RESET;
        end else if (wr && addr == `DSC_CTRL_OFS && !busy) begin
            ctrl <= {wdata[7:1], 1'b0};
        end else if (wr && addr == `DSC_DIVIDER_OFS) begin
            divider <= (wdata[7:0] == 8'h00) ? 8'h01 : wdata[7:0];
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_shift <= 54'h0;
        end else if (wr && addr == `DSC_TXDATA_OFS && !busy) begin
            tx_shift <= {tx_shift[35:0], wdata[17:0]};
        end else if (state == H_HIGH && div_cnt == 8'h00) begin
            tx_shift <= {tx_shift[52:0], 1'b0};
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0;
        end else if (rd) begin
            unique case (addr)
                `DSC_CTRL_OFS: rdata <= {24'h0, ctrl};
                `DSC_RXDATA_OFS: rdata <= {14'h0, rx_word};
                `DSC_STATUS_OFS: rdata <= {30'h0, done, busy};
                `DSC_DIVIDER_OFS: rdata <= {24'h0, divider};
                default: rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end
    assign busy = (state != H_IDLE);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= H_IDLE;
            div_cnt <= 8'h00;
            bit_cnt <= '0;
            gap_cnt <= 8'h00;
            rx_shift <= `DSC_RESET_ZERO;
            rx_word <= `DSC_RESET_ZERO;
            done <= 1'b0;
        end else begin
            if (rd && addr == `DSC_STATUS_OFS) done <= 1'b0;
            unique case (state)
                H_IDLE: if (start) begin
                    state <= H_LOW;
                    div_cnt <= divider;
                    bit_cnt <= '0;
                end
                H_LOW: if (div_cnt == 8'h00) begin
                    state <= H_HIGH;
                    div_cnt <= divider;
                end else div_cnt <= div_cnt - 8'h01;
                H_HIGH: if (div_cnt == 8'h00) begin
                    // bit of the last rise, past the sync delay
                    rx_shift <= {rx_shift[`DSC_WORD_BITS-2:0], sdo_s[1]};
                    bit_cnt <= bit_cnt + 1'b1;
                    div_cnt <= divider;
                    // all chained words in one frame
                    state <= (bit_cnt + 1'b1 == total_bits) ? H_END : H_LOW;
                end else div_cnt <= div_cnt - 8'h01;
                H_END: if (div_cnt == 8'h00) begin
                    state <= H_GAP;
                    gap_cnt <= 8'(`DSC_CS_HIGH_CYC);
                    rx_word <= rx_shift;
                end else div_cnt <= div_cnt - 8'h01;
                H_GAP: if (gap_cnt == 8'h00) begin
                    state <= ctrl[3] ? H_LOAD : H_IDLE;
                    gap_cnt <= 8'(`DSC_LOAD_LOW_CYC);
                    done <= !ctrl[3];
                end else gap_cnt <= gap_cnt - 8'h01;
                H_LOAD: if (gap_cnt == 8'h00) begin
                    state <= H_IDLE;
                    done <= 1'b1;
                end else gap_cnt <= gap_cnt - 8'h01;
                default: state <= H_IDLE;
            endcase
        end
    end
    // clock idles low; select low before first rise
    assign link.sclk = (state == H_HIGH);
    assign link.cs_n = !(state == H_LOW || state == H_HIGH || state == H_END);
    assign link.sdi = tx_shift[8'(total_bits) - 8'h01 > 8'd53 ? 53 : total_bits - 1'b1];
    assign link.load_latch_n = !(state == H_LOAD);
endmodule : dsc_host

// file: testbench/dsc_link_chk.sv
// assertions on the serial link between host and converter ends
`timescale 1ns/1ps
module dsc_link_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic cs_n,
    input wire logic load_latch_n,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic sdo_i
);
    logic prev_sclk;
    logic [5:0] rise_cnt;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_sclk <= 1'b0;
        end else begin
            prev_sclk <= sclk;
        end
    end
    // counts clock rises inside one frame
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rise_cnt <= 6'h00;
        end else if (cs_n) begin
            rise_cnt <= 6'h00;
        end else if (sclk && !prev_sclk) begin
            rise_cnt <= rise_cnt + 6'h01;
        end
    end
    property p_oe_off; cs_n [*4] |-> !sdo_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("sdo driven outside frame");
    property p_oe_on; $fell(cs_n) |-> ##[1:6] sdo_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("sdo not driven in frame");
    property p_sdo_hold; sclk && $past(sclk) && !cs_n && !$past(cs_n) |-> $stable(sdo_o);
    endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved while clock high");
    property p_cs_fall; $fell(cs_n) |-> !sclk; endproperty
    a_cs_fall: assert property (p_cs_fall) else $error("frame began with clock high");
    property p_rise_in; $rose(sclk) |-> !cs_n && !$past(cs_n); endproperty
    a_rise_in: assert property (p_rise_in) else $error("clock rose outside frame");
    property p_gap; $rose(cs_n) |-> cs_n [*2]; endproperty
    a_gap: assert property (p_gap) else $error("select high gap too short");
    property p_load; $fell(load_latch_n) |-> cs_n && $past(cs_n); endproperty
    a_load: assert property (p_load) else $error("load pulse inside frame");
    property p_bits; $rose(cs_n) |-> rise_cnt inside {6'h12, 6'h24, 6'h36}; endproperty
    a_bits: assert property (p_bits) else $error("frame not whole words");
    c_single: cover property ($rose(cs_n) && rise_cnt == 6'h12);
    c_chain: cover property ($rose(cs_n) && rise_cnt == 6'h24);
    c_load: cover property ($fell(load_latch_n));
endmodule : dsc_link_chk

// file: testbench/dac_serial_input_control_test.sv
// self-checking bench for host and converter ends joined by the link
`timescale 1ns/1ps
`include "dsc_regs.svh"
module dac_serial_input_control_test;
    import dsc_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, reset_n = 1'b1, reset_value_select = 1'b1;
    logic gain_select = 1'b0, number_format_select = 1'b1, power_down_in = 1'b0;
    logic readback_source_select = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rv;
    dsc_word_t latch_code, dac_code;
    dsc_gain_t buffer_gain;
    logic output_driven, output_grounded;
    int err_total = 0, n_compared = 0;
    always #25 mclk = ~mclk;
    dsc_link_if dsc_link_if_inst ();
    assign dsc_link_if_inst.sdo_i = dsc_link_if_inst.sdo_oe ? dsc_link_if_inst.sdo_o : 1'bz;
    dsc_device dsc_device_inst (.mclk(mclk), .rst(rst), .link(dsc_link_if_inst.dev),
        .reset_n(reset_n), .reset_value_select(reset_value_select), .gain_select(gain_select),
        .number_format_select(number_format_select), .power_down_in(power_down_in),
        .readback_source_select(readback_source_select), .latch_code(latch_code),
        .dac_code(dac_code), .buffer_gain(buffer_gain), .output_driven(output_driven),
        .output_grounded(output_grounded));
    dsc_host dsc_host_inst (.mclk(mclk), .rst(rst), .link(dsc_link_if_inst.host),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    dsc_link_chk dsc_link_chk_inst (.mclk(mclk), .rst(rst), .sclk(dsc_link_if_inst.sclk),
        .sdi(dsc_link_if_inst.sdi), .cs_n(dsc_link_if_inst.cs_n),
        .load_latch_n(dsc_link_if_inst.load_latch_n), .sdo_o(dsc_link_if_inst.sdo_o),
        .sdo_oe(dsc_link_if_inst.sdo_oe), .sdo_i(dsc_link_if_inst.sdo_i));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [3:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask : bus_rd
    // one frame of one or two words, waits for done
    task automatic send(input dsc_word_t a, input dsc_word_t b, input logic two, input logic ld);
        int i;
        bus_wr(`DSC_TXDATA_OFS, {14'h0000, a});
        if (two) begin
            bus_wr(`DSC_TXDATA_OFS, {14'h0000, b});
        end
        bus_wr(`DSC_CTRL_OFS, {28'h0000000, ld, 1'b0, two, 1'b1});
        rv = 32'h0;
        for (i = 0; i < 400 && rv[1] !== 1'b1; i++) begin
            bus_rd(`DSC_STATUS_OFS);
        end
        chk("done", 32'h1, {31'h0, rv[1]});
        repeat (6) @(posedge mclk);
    endtask : send
    task automatic chk_rx(input dsc_word_t w);
        bus_rd(`DSC_RXDATA_OFS);
        chk("readback", {14'h0000, w}, rv);
    endtask : chk_rx
    task automatic t_reset;
        int v;
        repeat (6) @(posedge mclk);
        chk("power-on code", 32'h20000, {14'h0, latch_code});
        chk("power-on dac", 32'h20000, {14'h0, dac_code});
        for (v = 0; v < 2; v++) begin
            @(posedge mclk);
            reset_value_select <= v[0];
            reset_n <= 1'b0;
            repeat (8) @(posedge mclk);
            reset_n <= 1'b1;
            repeat (4) @(posedge mclk);
            chk("reset code", v[0] ? 32'h20000 : 32'h0, {14'h0, latch_code});
        end
        $display("test reset done");
    endtask : t_reset
    task automatic t_gain;
        int v;
        for (v = 0; v < 2; v++) begin
            @(posedge mclk);
            gain_select <= v[0];
            repeat (4) @(posedge mclk);
            chk("gain", 32'(v[0] ? DSC_GAIN_TWO : DSC_GAIN_ONE), 32'(buffer_gain));
        end
        $display("test gain done");
    endtask : t_gain
    task automatic t_stand;
        send(18'h2A5C3, 18'h00000, 1'b0, 1'b0);
        chk("latch held", 32'h20000, {14'h0, latch_code});
        chk_rx(18'h20000);
        send(18'h15A3C, 18'h00000, 1'b0, 1'b1);
        chk("latch", 32'h15A3C, {14'h0, latch_code});
        chk_rx(18'h2A5C3);
        $display("test stand-alone done");
    endtask : t_stand
    task automatic t_twos;
        @(posedge mclk);
        number_format_select <= 1'b0;
        send(18'h00005, 18'h00000, 1'b0, 1'b1);
        chk("twos latch", 32'h20005, {14'h0, latch_code});
        $display("test twos done");
    endtask : t_twos
    task automatic t_daisy;
        @(posedge mclk);
        number_format_select <= 1'b1;
        readback_source_select <= 1'b0;
        send(18'h0F0F0, 18'h30303, 1'b1, 1'b1);
        chk("chain latch", 32'h30303, {14'h0, latch_code});
        chk_rx(18'h0F0F0);
        $display("test daisy done");
    endtask : t_daisy
    task automatic t_pdn;
        @(posedge mclk);
        power_down_in <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("grounded", 32'h1, {31'h0, output_grounded});
        chk("driven", 32'h0, {31'h0, output_driven});
        chk("pdn code", 32'h0, {14'h0, dac_code});
        power_down_in <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("grounded", 32'h0, {31'h0, output_grounded});
        chk("code", 32'h30303, {14'h0, dac_code});
        $display("test power down done");
    endtask : t_pdn
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_gain;
        t_stand;
        t_twos;
        t_daisy;
        t_pdn;
        close_out;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        close_out;
    end
endmodule : dac_serial_input_control_test
